// [rtl/gpp_port.sv]
// General-purpose port block: four ports, registers, pin muxing and overrides
//
// Overview of operation
// (RULE_01) Up to 25 pins are provided over ports A to D.
// (RULE_02) Each pin has its own direction, open-drain, drive, pull-up, wake and alt bits.
// (RULE_03) Package and converter option inputs decide which port B and C pins exist.
// (RULE_04) An alternate-function pin takes its enable and direction from its peripheral.
// (RULE_05) First and second select registers with the enable pick the peripheral function.
// (RULE_06) While the crystal is enabled, port A bits zero and one ignore port settings; their wake bits still raise stop_wake.
// (RULE_07) Port A bits zero and six share one setup for timer in or complement out.
// (RULE_08) Enabled port C pins sink LED current at one of four levels.
// (RULE_09) After reset port D bit zero is an open-drain reset pin with pull-up.
// (RULE_10) In general use port D bit zero is output only, set so by software.
// (RULE_11) Port D bit zero has high drive but never wakes from stop.
// (RULE_12) Ports A and D have no select registers, only the enable.
// (RULE_13) A set first-select bit on port B picks the analog function.
// (RULE_14) All pins but port D bit zero leave reset as plain pins, alt disabled.
`timescale 1ns/1ps
`default_nettype none
`include "gpp_defines.svh"
module gpp_port (
   input wire logic core_clk,               // System clock
   input wire logic rst_b,                  // Asynchronous reset, active low
   input wire logic [7:0] reg_addr,         // Register address, port and sub-register
   input wire logic [7:0] reg_wdata,        // Write data
   input wire logic reg_wr,                 // Write strobe
   input wire logic reg_rd,                 // Read strobe
   output logic [7:0] reg_rdata,            // Read data, cycle after the strobe
   input wire logic opt_pkg_28pin,          // Option: larger package
   input wire logic opt_adc_en,             // Option: converter present
   input wire logic xtal_en,                // Crystal oscillator enabled
   input wire logic stop_mode,              // Device is in stop mode
   input wire logic chip_rst_req,           // Internal reset to drive out
   input wire logic [31:0] pin_in,          // Pin levels D,C,B,A
   output logic [31:0] pin_out,             // Pin output value
   output logic [31:0] pin_oe,              // Pin output enable
   output logic [31:0] pin_pu,              // Pull-up enable
   output logic [31:0] pin_hd,              // High drive enable
   input wire logic [31:0] periph_out,      // Peripheral output per pin
   input wire logic [31:0] periph_oe,       // Peripheral output enable per pin
   output logic [31:0] periph_in,           // Sampled pin levels to peripherals
   output logic [31:0] alt_en,              // Alternate function active per pin
   output logic [15:0] alt_sel_first,       // First select, ports C,B
   output logic [15:0] alt_sel_second,      // Second select, ports C,B
   output logic [7:0] led_en,               // Port C LED sink enable
   output logic [15:0] led_level,           // Port C LED level, two bits a pin
   output logic stop_wake,                  // Stop-mode wake pulse
   output logic ext_reset                   // Reset pin pulled low
);
   gpp_pkg::gpp_state_s q;
   gpp_pkg::gpp_state_s d;
   gpp_pkg::gpp_port_t nx_out;
   gpp_pkg::gpp_port_t nx_oe;
   gpp_pkg::gpp_port_t nx_pu;
   gpp_pkg::gpp_port_t nx_hd;
   gpp_pkg::gpp_port_t av;
   logic [3:0] port_sel;
   logic [3:0] sub_sel;
   logic [1:0] pi;

   // (RULE_03) Pin set from option bits
   function automatic logic [31:0] avail_mask(input logic pkg28, input logic adc);
      logic [7:0] b;
      logic [7:0] c;
      b = pkg28 ? (adc ? `GPP_AV_B28ADC : `GPP_AV_FULL) : `GPP_AV_B20;
      c = pkg28 ? `GPP_AV_FULL : `GPP_AV_C20;
      return {`GPP_AV_D, c, b, `GPP_AV_FULL};
   endfunction : avail_mask

   function automatic logic is_bc(input logic [3:0] p);
      return (p == `GPP_PORT_B) || (p == `GPP_PORT_C);
   endfunction : is_bc

   assign av = avail_mask(opt_pkg_28pin, opt_adc_en);
   assign port_sel = reg_addr[7:4];
   assign sub_sel = reg_addr[3:0];
   assign pi = port_sel[1:0];

   // (RULE_01) Four byte-wide ports
   // (RULE_02) One mux per port
   for (genvar g = 0; g < 4; g++) begin : g_port
      gpp_pin_mux u_mux (
         .avail(av[g]),
         .outr(q.outr[g]),
         .dir(q.dir[g]),
         .afen(q.afen[g]),
         .od(q.od[g]),
         .pu(q.pu[g]),
         .hd(q.hd[g]),
         .periph_out(periph_out[g*8 +: 8]),
         .periph_oe(periph_oe[g*8 +: 8]),
         .nx_out(nx_out[g]),
         .nx_oe(nx_oe[g]),
         .nx_pu(nx_pu[g]),
         .nx_hd(nx_hd[g])
      );
   end

   function automatic logic [7:0] reg_read(input gpp_pkg::gpp_state_s s,
                                          input logic [3:0] p, input logic [3:0] sub,
                                          input logic [7:0] a);
      logic [7:0] r;
      logic [1:0] k;
      r = `GPP_ZERO8;
      k = p[1:0];
      if (p == `GPP_PORT_CTL) begin
         if (sub == `GPP_SUB_CTL) begin
            r[`GPP_CTL_RSTMODE] = s.rst_mode;
         end
      end else if (p <= `GPP_PORT_D) begin
         unique case (sub)
            `GPP_SUB_IN: r = s.pin_in[k*8 +: 8];
            `GPP_SUB_OUT: r = s.outr[k];
            `GPP_SUB_DIR: r = s.dir[k];
            `GPP_SUB_AFEN: r = s.afen[k];
            `GPP_SUB_OD: r = s.od[k];
            `GPP_SUB_HD: r = s.hd[k];
            `GPP_SUB_PU: r = s.pu[k];
            `GPP_SUB_SMR: r = s.smr[k];
            // (RULE_12) No select registers on A and D
            `GPP_SUB_ALT_FUNC_SELECT_FIRST: r = is_bc(p) ? s.alt_func_select_first[k[0] ^ 1'b1] : `GPP_ZERO8;
            `GPP_SUB_ALT_FUNC_SELECT_SECOND: r = is_bc(p) ? s.alt_func_select_second[k[0] ^ 1'b1] : `GPP_ZERO8;
            `GPP_SUB_LEDEN: r = (p == `GPP_PORT_C) ? s.led_en : `GPP_ZERO8;
            `GPP_SUB_LEDLO: r = (p == `GPP_PORT_C) ? s.led_lvl[7:0] : `GPP_ZERO8;
            `GPP_SUB_LEDHI: r = (p == `GPP_PORT_C) ? s.led_lvl[15:8] : `GPP_ZERO8;
            default: r = `GPP_ZERO8;
         endcase
         // (RULE_03) Missing pins read zero
         r = r & a;
      end
      return r;
   endfunction : reg_read

   always_comb begin
      d = q;
      d.wake = 1'b0;
      if (reg_wr) begin
         d.wr_seen = 1'b1;
         if (port_sel == `GPP_PORT_CTL) begin
            if (sub_sel == `GPP_SUB_CTL) begin
               // (RULE_09) Software releases the reset pin
               d.rst_mode = reg_wdata[`GPP_CTL_RSTMODE];
            end
         end else if (port_sel <= `GPP_PORT_D) begin
            unique case (sub_sel)
               `GPP_SUB_OUT: d.outr[pi] = reg_wdata;
               `GPP_SUB_DIR: d.dir[pi] = reg_wdata;
               `GPP_SUB_AFEN: d.afen[pi] = reg_wdata;
               `GPP_SUB_OD: d.od[pi] = reg_wdata;
               `GPP_SUB_HD: d.hd[pi] = reg_wdata;
               `GPP_SUB_PU: d.pu[pi] = reg_wdata;
               `GPP_SUB_SMR: d.smr[pi] = reg_wdata;
               // (RULE_05) Select registers for B and C
               `GPP_SUB_ALT_FUNC_SELECT_FIRST: begin
                  if (is_bc(port_sel)) begin
                     d.alt_func_select_first[pi[0] ^ 1'b1] = reg_wdata;
                  end
               end
               `GPP_SUB_ALT_FUNC_SELECT_SECOND: begin
                  if (is_bc(port_sel)) begin
                     d.alt_func_select_second[pi[0] ^ 1'b1] = reg_wdata;
                  end
               end
               `GPP_SUB_LEDEN: begin
                  if (port_sel == `GPP_PORT_C) begin
                     d.led_en = reg_wdata;
                  end
               end
               `GPP_SUB_LEDLO: begin
                  if (port_sel == `GPP_PORT_C) begin
                     d.led_lvl[7:0] = reg_wdata;
                  end
               end
               `GPP_SUB_LEDHI: begin
                  if (port_sel == `GPP_PORT_C) begin
                     d.led_lvl[15:8] = reg_wdata;
                  end
               end
               default: d.wr_seen = 1'b1;
            endcase
         end
      end
      d.rdata = reg_rd ? reg_read(q, port_sel, sub_sel, av[pi]) : `GPP_ZERO8;

      // (RULE_10) Port D bit zero reads no input
      d.pin_in = pin_in & av & ~`GPP_PD0_MASK;
      // (RULE_11) Wake excludes port D bit zero
      d.wake = stop_mode & (|((pin_in ^ q.pin_in) & q.smr & av & ~`GPP_PD0_MASK));

      d.pin_out = nx_out;
      d.pin_oe = nx_oe;
      d.pin_pu = nx_pu;
      d.pin_hd = nx_hd;
      // (RULE_08) LED sink on port C when data is one
      for (int k = 0; k < 8; k++) begin
         if (q.led_en[k] && !q.afen[2][k] && av[2][k]) begin
            d.pin_oe[`GPP_C_LSB + k] = q.outr[2][k];
            d.pin_out[`GPP_C_LSB + k] = 1'b0;
            d.pin_pu[`GPP_C_LSB + k] = 1'b0;
         end
      end
      // (RULE_06) Crystal overrides port A bits zero and one
      if (xtal_en) begin
         d.pin_oe[`GPP_PIN_XOUT:`GPP_PIN_XIN] = 2'h0;
         d.pin_out[`GPP_PIN_XOUT:`GPP_PIN_XIN] = 2'h0;
         d.pin_pu[`GPP_PIN_XOUT:`GPP_PIN_XIN] = 2'h0;
         d.pin_hd[`GPP_PIN_XOUT:`GPP_PIN_XIN] = 2'h0;
         d.pin_in[`GPP_PIN_XOUT:`GPP_PIN_XIN] = 2'h0;
      end
      // (RULE_09) Open-drain reset pin with pull-up
      if (q.rst_mode) begin
         d.pin_oe[`GPP_PIN_PD0] = chip_rst_req;
         d.pin_out[`GPP_PIN_PD0] = 1'b0;
         d.pin_pu[`GPP_PIN_PD0] = 1'b1;
         d.pin_hd[`GPP_PIN_PD0] = 1'b0;
      end
      d.ext_rst = q.rst_mode & ~pin_in[`GPP_PIN_PD0];

      // (RULE_13) Set first-select bit picks analog
      d.alt_en = q.afen & av;
      d.sel1 = {q.alt_func_select_first[1] & q.afen[2] & av[2], q.alt_func_select_first[0] & q.afen[1] & av[1]};
      d.sel2 = {q.alt_func_select_second[1] & q.afen[2] & av[2], q.alt_func_select_second[0] & q.afen[1] & av[1]};
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         // (RULE_14) Plain pins, alt disabled
         q <= '0;
         q.dir <= {4{`GPP_DIR_RST}};
         q.rst_mode <= 1'b1;
         q.pin_pu <= `GPP_PD0_MASK;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata = q.rdata;
   assign pin_out = q.pin_out;
   assign pin_oe = q.pin_oe;
   assign pin_pu = q.pin_pu;
   assign pin_hd = q.pin_hd;
   assign periph_in = q.pin_in;
   assign alt_en = q.alt_en;
   assign alt_sel_first = q.sel1;
   assign alt_sel_second = q.sel2;
   assign led_en = q.led_en;
   assign led_level = q.led_lvl;
   assign stop_wake = q.wake;
   assign ext_reset = q.ext_rst;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_dir_write(logic [3:0] p);
      reg_wr && reg_addr == {p, `GPP_SUB_DIR};
   endsequence
   sequence s_dir_read(logic [3:0] p);
      ##1 reg_rd && reg_addr == {p, `GPP_SUB_DIR};
   endsequence

   a_pin_count_limit: assert property ( // RULE_01
      $countones(avail_mask(opt_pkg_28pin, opt_adc_en)) <= `GPP_MAX_PINS)
      else $error("more pins available than the port supports");
   a_dir_write_read: assert property ( // RULE_02
      s_dir_write(`GPP_PORT_A) ##0 s_dir_read(`GPP_PORT_A) |=> reg_rdata == $past(reg_wdata, 2))
      else $error("direction write not read back");
   a_small_pkg_low: assert property ( // RULE_03
      !opt_pkg_28pin |=> pin_oe[15:12] == 4'hF && pin_out[15:12] == 4'h0)
      else $error("missing port B pins not held low");
   a_alt_oe_follow: assert property ( // RULE_04
      1'b1 |=> ((pin_oe[15:8] ^ $past(periph_oe[15:8])) & $past(q.afen[1] & av[1] & ~q.od[1]))
               == 8'h00)
      else $error("alternate pin enable not from peripheral");
   a_afs_for_bc: assert property ( // RULE_05
      reg_wr && reg_addr == {`GPP_PORT_C, `GPP_SUB_ALT_FUNC_SELECT_SECOND} |=> q.alt_func_select_second[1] == $past(reg_wdata))
      else $error("second select write lost");
   a_xtal_override: assert property ( // RULE_06
      xtal_en |=> pin_oe[1:0] == 2'h0 && pin_pu[1:0] == 2'h0)
      else $error("crystal pins still driven by port logic");
   a_timer_pin_dir: assert property ( // RULE_07
      q.afen[0][6] |=> pin_oe[6] == $past(periph_oe[6] & ~(q.od[0][6] & periph_out[6])))
      else $error("timer pin enable not from timer");
   a_led_sink_on: assert property ( // RULE_08
      q.led_en[0] && q.outr[2][0] && !q.afen[2][0] |=> pin_oe[16] && !pin_out[16])
      else $error("LED sink not active");
   a_reset_pin_drive: assert property ( // RULE_09
      q.rst_mode |=> pin_oe[`GPP_PIN_PD0] == $past(chip_rst_req) && pin_pu[`GPP_PIN_PD0]
                     && !pin_out[`GPP_PIN_PD0])
      else $error("reset pin not open-drain with pull-up");
   a_pd0_output_only: assert property ( // RULE_10
      !q.rst_mode && !q.afen[3][0] && !q.od[3][0] |=> pin_oe[`GPP_PIN_PD0] == !$past(q.dir[3][0])
                     && periph_in[`GPP_PIN_PD0] == 1'b0)
      else $error("port D bit zero output path wrong");
   a_pd0_no_wake: assert property ( // RULE_11
      ((pin_in ^ q.pin_in) & ~`GPP_PD0_MASK) == 32'h0000_0000 |=> !stop_wake)
      else $error("port D bit zero caused wake");
   a_no_afs_port_a: assert property ( // RULE_12
      reg_rd && reg_addr == {`GPP_PORT_A, `GPP_SUB_ALT_FUNC_SELECT_FIRST} |=> reg_rdata == 8'h00)
      else $error("select register present on port A");
   a_alt_func_select_first_analog: assert property ( // RULE_13
      1'b1 |=> alt_sel_first[7:0] == $past(q.alt_func_select_first[0] & q.afen[1] & av[1]))
      else $error("port B first select not exported");
   a_reset_defaults: assert property ( // RULE_14
      !q.wr_seen |-> q.afen == 32'h0000_0000 && q.rst_mode)
      else $error("pins not plain after reset");
   a_rdata_idle: assert property ( // RULE_02
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data present without a read");
   a_missing_c_low: assert property ( // RULE_03
      !opt_pkg_28pin |=> pin_oe[23:20] == 4'hF && pin_pu[23:20] == 4'h0)
      else $error("missing port C pins not held low");
   a_alt_sel_gate: assert property ( // RULE_05
      !q.afen[1][3] |=> !alt_sel_first[3])
      else $error("select exported without alternate enable");
   a_xtal_in_zero: assert property ( // RULE_06
      xtal_en |=> periph_in[1:0] == 2'h0)
      else $error("crystal pins still seen as inputs");
   a_led_no_pullup: assert property ( // RULE_08
      q.led_en[0] && !q.afen[2][0] |=> !pin_pu[16])
      else $error("pull-up left on LED sink pin");
   a_reset_mode_hd: assert property ( // RULE_09
      q.rst_mode |=> !pin_hd[`GPP_PIN_PD0])
      else $error("high drive on reset pin");
   a_ext_reset_off: assert property ( // RULE_09
      !q.rst_mode |=> !ext_reset)
      else $error("reset flagged while pin is general purpose");
   a_pd0_high_drive: assert property ( // RULE_11
      !q.rst_mode && q.hd[3][0] |=> pin_hd[`GPP_PIN_PD0])
      else $error("port D bit zero high drive missing");
   a_wake_needs_stop: assert property ( // RULE_11
      !stop_mode |=> !stop_wake)
      else $error("wake outside stop mode");
   a_pd0_no_afs: assert property ( // RULE_12
      reg_rd && reg_addr == {`GPP_PORT_D, `GPP_SUB_ALT_FUNC_SELECT_FIRST} |=> reg_rdata == 8'h00)
      else $error("select register present on port D");
endmodule : gpp_port
`default_nettype wire

// [rtl/gpp_defines.svh]
// Register offsets, reset values and pin constants for the general-purpose port block
`ifndef GPP_DEFINES_SVH
`define GPP_DEFINES_SVH
// Sub-register index in reg_addr[3:0]
`define GPP_SUB_IN 4'h0
`define GPP_SUB_OUT 4'h1
`define GPP_SUB_DIR 4'h2
`define GPP_SUB_AFEN 4'h3
`define GPP_SUB_OD 4'h4
`define GPP_SUB_HD 4'h5
`define GPP_SUB_PU 4'h6
`define GPP_SUB_SMR 4'h7
`define GPP_SUB_ALT_FUNC_SELECT_FIRST 4'h8
`define GPP_SUB_ALT_FUNC_SELECT_SECOND 4'h9
`define GPP_SUB_LEDEN 4'hA
`define GPP_SUB_LEDLO 4'hB
`define GPP_SUB_LEDHI 4'hC
// Port index in reg_addr[7:4]
`define GPP_PORT_A 4'h0
`define GPP_PORT_B 4'h1
`define GPP_PORT_C 4'h2
`define GPP_PORT_D 4'h3
`define GPP_PORT_CTL 4'h4
`define GPP_SUB_CTL 4'h0
`define GPP_CTL_RSTMODE 0
// Reset values
`define GPP_DIR_RST 8'hFF
`define GPP_ZERO8 8'h00
// Pin availability per package and converter option
`define GPP_AV_FULL 8'hFF
`define GPP_AV_B20 8'h0F
`define GPP_AV_B28ADC 8'h3F
`define GPP_AV_C20 8'h0F
`define GPP_AV_D 8'h01
`define GPP_MAX_PINS 25
// Pin indices in the flat 32-bit pin vector
`define GPP_PIN_XIN 0
`define GPP_PIN_XOUT 1
`define GPP_PIN_PD0 24
`define GPP_PD0_MASK 32'h0100_0000
`define GPP_C_LSB 16
`endif

// [rtl/gpp_pkg.sv]
// Types shared by the general-purpose port block
package gpp_pkg;
   typedef logic [3:0][7:0] gpp_port_t;
   typedef logic [1:0][7:0] gpp_bc_t;
   typedef struct packed {
      gpp_port_t outr;
      gpp_port_t dir;
      gpp_port_t afen;
      gpp_port_t od;
      gpp_port_t hd;
      gpp_port_t pu;
      gpp_port_t smr;
      gpp_bc_t alt_func_select_first;
      gpp_bc_t alt_func_select_second;
      logic [7:0] led_en;
      logic [15:0] led_lvl;
      logic rst_mode;
      logic wr_seen;
      logic [31:0] pin_in;
      logic [31:0] pin_out;
      logic [31:0] pin_oe;
      logic [31:0] pin_pu;
      logic [31:0] pin_hd;
      logic [31:0] alt_en;
      logic [15:0] sel1;
      logic [15:0] sel2;
      logic [7:0] rdata;
      logic wake;
      logic ext_rst;
   } gpp_state_s;
endpackage : gpp_pkg

// [rtl/gpp_pin_mux.sv]
// Per-port pin output, enable, pull-up and drive selection
`timescale 1ns/1ps
`default_nettype none
module gpp_pin_mux (
   input wire logic [7:0] avail,      // Pin exists in this package
   input wire logic [7:0] outr,       // Output data register
   input wire logic [7:0] dir,        // Direction, 1 = input
   input wire logic [7:0] afen,       // Alternate function enable
   input wire logic [7:0] od,         // Open-drain enable
   input wire logic [7:0] pu,         // Pull-up enable
   input wire logic [7:0] hd,         // High drive enable
   input wire logic [7:0] periph_out, // Peripheral output value
   input wire logic [7:0] periph_oe,  // Peripheral output enable
   output logic [7:0] nx_out,         // Next pin output
   output logic [7:0] nx_oe,          // Next pin output enable
   output logic [7:0] nx_pu,          // Next pull-up
   output logic [7:0] nx_hd           // Next high drive
);
   logic [7:0] sel_oe;
   logic [7:0] val;
   always_comb begin
      // (RULE_04) Peripheral owns direction
      // (RULE_07) Timer mode picks pin direction
      sel_oe = (afen & periph_oe) | (~afen & ~dir);
      val = (afen & periph_out) | (~afen & outr);
      // (RULE_02) Open-drain drives low only
      // Missing pins are held driven low
      nx_oe = (sel_oe & ~(od & val) & avail) | ~avail;
      nx_out = val & avail;
      nx_pu = pu & avail;
      nx_hd = hd & avail;
   end
endmodule : gpp_pin_mux
`default_nettype wire

// [verif/gpp_pin_model.sv]
// Far-side model of the pads and external drivers of the port block
`timescale 1ns/1ps
`default_nettype none
module gpp_pin_model (
   input wire logic core_clk,       // System clock
   input wire logic [31:0] pin_out, // Pin value from the block
   input wire logic [31:0] pin_oe,  // Drive enable from the block
   input wire logic [31:0] pin_pu,  // Pull-up from the block
   input wire logic [31:0] ext_en,  // Outside world drives the pin
   input wire logic [31:0] ext_lvl, // Level driven from outside
   output logic [31:0] pin_in       // Resolved pad level
);
   logic [31:0] float_q = 32'h0000_0000;
   // Floating pads change every cycle so a stale level is never read back
   always @(posedge core_clk) begin
      float_q <= ~float_q;
   end
   // released pad with pull-up and no outside driver reads high
   always_comb begin
      pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_lvl) |
         (~pin_oe & ~ext_en & pin_pu) | (~pin_oe & ~ext_en & ~pin_pu & float_q);
   end
endmodule : gpp_pin_model
`default_nettype wire

// [verif/tb.sv]
// Self-checking testbench of the general-purpose port block
`timescale 1ns/1ps
`default_nettype none
`include "gpp_defines.svh"
module tb;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic opt_pkg_28pin = 1'b1;
   logic opt_adc_en = 1'b0;
   logic xtal_en = 1'b0;
   logic stop_mode = 1'b0;
   logic chip_rst_req = 1'b0;
   logic [31:0] pin_in, pin_out, pin_oe, pin_pu, pin_hd, periph_in, alt_en;
   logic [31:0] periph_out = 32'h0000_0000;
   logic [31:0] periph_oe = 32'h0000_0000;
   logic [31:0] ext_en = 32'h0000_0000;
   logic [31:0] ext_lvl = 32'h0000_0000;
   logic [15:0] alt_sel_first, alt_sel_second, led_level;
   logic [7:0] led_en;
   logic stop_wake, ext_reset;
   int fails = 0;
   int total_checks = 0;
   int cyc = 0;
   int n;

   always #10 core_clk = ~core_clk;

   gpp_port i_gpp_port (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .opt_pkg_28pin(opt_pkg_28pin), .opt_adc_en(opt_adc_en), .xtal_en(xtal_en),
      .stop_mode(stop_mode), .chip_rst_req(chip_rst_req), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_pu(pin_pu), .pin_hd(pin_hd),
      .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in),
      .alt_en(alt_en), .alt_sel_first(alt_sel_first), .alt_sel_second(alt_sel_second),
      .led_en(led_en), .led_level(led_level), .stop_wake(stop_wake), .ext_reset(ext_reset));

   gpp_pin_model i_gpp_pin_model (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pu(pin_pu), .ext_en(ext_en), .ext_lvl(ext_lvl), .pin_in(pin_in));

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : stop_test

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         stop_test();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      check({24'h0, reg_rdata}, {24'h0, exp});
   endtask : rd_chk

   task automatic wr_rd_chk(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      check({24'h0, reg_rdata}, {24'h0, exp});
   endtask : wr_rd_chk

   task automatic settle();
      repeat (4) @(posedge core_clk);
      #1;
   endtask : settle

   task automatic count_wake();
      n = 0;
      repeat (6) begin
         @(posedge core_clk);
         #1;
         if (stop_wake === 1'b1) n++;
      end
   endtask : count_wake

   task automatic done(input string name);
      $display("Test %s finished", name);
   endtask : done

   initial begin
      repeat (5) @(posedge core_clk);
      rst_b <= 1'b1;
      #1;
      check(pin_oe, 32'h0);
      check(pin_pu, `GPP_PD0_MASK);
      rd_chk(8'h02, `GPP_DIR_RST);
      rd_chk(8'h03, 8'h00);
      rd_chk(8'h40, 8'h01);
      check(alt_en, 32'h0);
      done("reset");
      wr(8'h06, 8'hFF);
      wr(8'h16, 8'hFF);
      wr(8'h26, 8'hFF);
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         opt_pkg_28pin <= i[1];
         opt_adc_en <= i[0];
         settle();
         check($countones(pin_pu), (i < 2) ? 17 : (i == 3) ? 23 : 25);
         rd_chk(8'h16, (i < 2) ? 8'h0F : (i == 3) ? 8'h3F : 8'hFF);
         rd_chk(8'h26, (i < 2) ? 8'h0F : 8'hFF);
      end
      @(posedge core_clk);
      opt_pkg_28pin <= 1'b1;
      opt_adc_en <= 1'b0;
      done("availability");
      wr(8'h01, 8'hA5);
      wr_rd_chk(8'h02, 8'h00, 8'h00);
      settle();
      check(pin_oe[7:0], 8'hFF);
      check(pin_out[7:0], 8'hA5);
      rd_chk(8'h00, 8'hA5);
      wr(8'h04, 8'hFF);
      wr(8'h05, 8'h0F);
      settle();
      check(pin_oe[7:0], 8'h5A);
      check(pin_hd[7:0], 8'h0F);
      rd_chk(8'h00, 8'hA5);
      done("pin setup");
      wr(8'h04, 8'h00);
      periph_out <= 32'h0000_0040;
      periph_oe <= 32'h0000_0001;
      wr(8'h03, 8'h41);
      settle();
      check(alt_en[7:0], 8'h41);
      check(pin_oe[7:0], 8'hBF);
      check(pin_out[7:0] & pin_oe[7:0], 8'hA4);
      wr(8'h08, 8'hFF);
      rd_chk(8'h08, 8'h00);
      wr(8'h38, 8'hFF);
      rd_chk(8'h38, 8'h00);
      wr(8'h13, 8'h08);
      wr(8'h18, 8'h08);
      wr(8'h19, 8'h08);
      settle();
      check(alt_sel_first[7:0], 8'h08);
      check(alt_sel_second[7:0], 8'h08);
      rd_chk(8'h18, 8'h08);
      wr(8'h29, 8'h10);
      rd_chk(8'h29, 8'h10);
      wr(8'h18, 8'h00);
      settle();
      check(alt_sel_first[7:0], 8'h00);
      done("alternate");
      @(posedge core_clk);
      xtal_en <= 1'b1;
      settle();
      check(pin_oe[1:0], 2'h0);
      check(pin_out[1:0], 2'h0);
      check(periph_in[1:0], 2'h0);
      @(posedge core_clk);
      xtal_en <= 1'b0;
      settle();
      check(pin_oe[1:0], 2'h3);
      done("crystal");
      wr(8'h2A, 8'h01);
      wr(8'h21, 8'h01);
      settle();
      check(led_en, 8'h01);
      check(pin_oe[16], 1'b1);
      check(pin_out[16], 1'b0);
      for (int lv = 0; lv < 4; lv++) begin
         wr(8'h2B, lv[7:0]);
         settle();
         check(led_level[1:0], lv[1:0]);
      end
      rd_chk(8'h0A, 8'h00);
      done("led");
      @(posedge core_clk);
      chip_rst_req <= 1'b1;
      settle();
      check(pin_oe[24], 1'b1);
      check(pin_out[24], 1'b0);
      check(ext_reset, 1'b1);
      @(posedge core_clk);
      chip_rst_req <= 1'b0;
      settle();
      check(pin_oe[24], 1'b0);
      check(ext_reset, 1'b0);
      wr(8'h40, 8'h00);
      wr(8'h32, 8'h00);
      wr(8'h35, 8'h01);
      settle();
      check(pin_oe[24], 1'b1);
      check(pin_out[24], 1'b0);
      check(pin_hd[24], 1'b1);
      @(posedge core_clk);
      ext_en[2] <= 1'b1;
      wr(8'h02, 8'h04);
      wr(8'h07, 8'h04);
      wr(8'h37, 8'h01);
      stop_mode <= 1'b1;
      settle();
      wr(8'h31, 8'h01);
      count_wake();
      check(n, 0);
      @(posedge core_clk);
      ext_lvl[2] <= 1'b1;
      count_wake();
      check(n, 1);
      done("reset pin and wake");
      stop_test();
   end
endmodule : tb
`default_nettype wire
